//--- hcs_pkg.sv
// Constants for the hub configuration current, language and string registers
package hcs_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam logic [7:0] OFF_CUR_SELF = 8'h0E;
    localparam logic [7:0] OFF_CUR_BUS = 8'h0F;
    localparam logic [7:0] OFF_SETTLE = 8'h10;
    localparam logic [7:0] OFF_LANG_UP = 8'h11;
    localparam logic [7:0] OFF_LANG_LO = 8'h12;
    localparam logic [7:0] OFF_MAKER_LEN = 8'h13;
    localparam logic [7:0] OFF_PART_LEN = 8'h14;
    localparam logic [7:0] OFF_UNIT_LEN = 8'h15;
    localparam logic [7:0] OFF_TEXT_FIRST = 8'h16;
    localparam logic [7:0] OFF_TEXT_LAST = 8'h53;
    localparam logic [7:0] RST_CUR_BUS = 8'h32;
    localparam logic [7:0] RST_OTHER = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;
    localparam logic [4:0] TEXT_MAX_CHARS = 5'h1F;
    localparam int unsigned CHAR_IDX_W = 5;
    localparam int unsigned CHAR_W = 16;
    localparam int unsigned TEXT_WORDS = 32;
    localparam int unsigned MA_W = 9;
    // Settle unit 2 ms, clock 40 MHz
    localparam int unsigned SETTLE_UNIT_US = 2000;
    localparam int unsigned CLK_MHZ = 40;
    localparam int unsigned SETTLE_UNIT_CYC = SETTLE_UNIT_US * CLK_MHZ;
    localparam int unsigned UNIT_CNT_W = 17;
    typedef enum logic [1:0] {
        SETTLE_IDLE = 2'b00,
        SETTLE_WAIT = 2'b01,
        SETTLE_DONE = 2'b10
    } hcs_settle_type;
endpackage

//--- hcs_text_if.sv
// Carrier between the register bank and the text storage memory
`timescale 1ns/1ps
interface hcs_text_if;
    import hcs_pkg::*;
    logic we;
    logic [CHAR_IDX_W-1:0] wr_idx;
    logic wr_hi;
    logic [DATA_W-1:0] wdata;
    logic [CHAR_IDX_W-1:0] ra_idx;
    logic [CHAR_W-1:0] ra_word;
    logic [CHAR_IDX_W-1:0] rb_idx;
    logic [CHAR_W-1:0] rb_word;
    modport bank (output we, wr_idx, wr_hi, wdata, ra_idx, rb_idx,
                  input ra_word, rb_word);
    modport mem (input we, wr_idx, wr_hi, wdata, ra_idx, rb_idx,
                 output ra_word, rb_word);
endinterface

//--- hcs_text_mem.sv
// Character store: 16-bit words, byte lanes, two registered read ports
`timescale 1ns/1ps
module hcs_text_mem import hcs_pkg::*; (
    input wire logic ref_clk_i,
    hcs_text_if.mem tif
);
    logic [CHAR_W-1:0] mem_r [TEXT_WORDS];
    logic [CHAR_W-1:0] ra_r;
    logic [CHAR_W-1:0] rb_r;

    // Even byte offset is the low lane, odd the high lane
    always_ff @(posedge ref_clk_i) begin
        if (tif.we && !tif.wr_hi) begin
            mem_r[tif.wr_idx][7:0] <= tif.wdata;
        end
        if (tif.we && tif.wr_hi) begin
            mem_r[tif.wr_idx][15:8] <= tif.wdata;
        end
        ra_r <= mem_r[tif.ra_idx];
        rb_r <= mem_r[tif.rb_idx];
    end

    assign tif.ra_word = ra_r;
    assign tif.rb_word = rb_r;
endmodule

//--- hcs_top.sv
// Hub configuration bank: controller current, settle time, language, text
`timescale 1ns/1ps
//
// Overview of operation
// - Self-powered current byte counts upstream draw in 2 mA steps.
// - Bus-powered current byte counts upstream draw in 2 mA steps.
// - Bus-powered current byte resets to 50, meaning 100 mA.
// - Both current values leave out any embedded compound peripheral.
// - Settle byte gives port power-on to stable delay in 2 ms steps.
// - Upper language byte supplies identifier bits 15 down to 8.
// - Lower language byte supplies identifier bits 7 down to 0.
// - Each text character count is at most 31.
// - Maker text lives at byte offsets 0x16 through 0x53.
// - Maker text holds at most 31 UTF-16LE characters, 62 bytes.
// - Each character stores low byte first, then high byte, contiguously.
module hcs_top import hcs_pkg::*; #(
    parameter int unsigned SETTLE_UNIT_CYCLES = SETTLE_UNIT_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic [ADDR_W-1:0] cfg_addr_i,
    input wire logic cfg_wr_i,
    input wire logic [DATA_W-1:0] cfg_wdata_i,
    input wire logic cfg_rd_i,
    output logic [DATA_W-1:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    output logic [MA_W-1:0] self_powered_ma_o,
    output logic [MA_W-1:0] bus_powered_ma_o,
    output logic [CHAR_W-1:0] language_id_o,
    output logic [4:0] maker_text_char_count_o,
    output logic [4:0] part_text_char_count_o,
    output logic [4:0] unit_number_text_char_count_o,
    input wire logic port_power_start_i,
    output logic port_power_stable_o,
    input wire logic [CHAR_IDX_W-1:0] text_char_idx_i,
    input wire logic text_char_rd_i,
    output logic [CHAR_W-1:0] text_char_o,
    output logic text_char_valid_o
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [4:0] clamp_count(input logic [7:0] raw);
        clamp_count = (raw > {3'h0, TEXT_MAX_CHARS}) ? TEXT_MAX_CHARS
                                                     : raw[4:0];
    endfunction

    function automatic logic in_text(input logic [7:0] a);
        in_text = (a >= OFF_TEXT_FIRST) && (a <= OFF_TEXT_LAST);
    endfunction

    logic [7:0] cur_self_r;
    logic [7:0] cur_bus_r;
    logic [7:0] settle_r;
    logic [7:0] lang_up_r;
    logic [7:0] lang_lo_r;
    logic [7:0] maker_len_r;
    logic [7:0] part_len_r;
    logic [7:0] unit_len_r;
    logic [MA_W-1:0] self_ma_r;
    logic [MA_W-1:0] bus_ma_r;
    logic [CHAR_W-1:0] lang_r;
    logic [7:0] reg_rd_r;
    logic rd_text_r;
    logic rd_hi_r;
    logic rd_pend_r;
    logic [7:0] rdata_r;
    logic rvalid_r;
    logic char_valid_r;

    ////////////////////////////////////////////////////////////////////////
    wire [7:0] text_off = cfg_addr_i - OFF_TEXT_FIRST;
    wire wr_text = cfg_wr_i && in_text(cfg_addr_i);
    wire wr_self = cfg_wr_i && (cfg_addr_i == OFF_CUR_SELF);
    wire wr_bus = cfg_wr_i && (cfg_addr_i == OFF_CUR_BUS);
    wire wr_settle = cfg_wr_i && (cfg_addr_i == OFF_SETTLE);
    wire wr_lang_up = cfg_wr_i && (cfg_addr_i == OFF_LANG_UP);
    wire wr_lang_lo = cfg_wr_i && (cfg_addr_i == OFF_LANG_LO);
    wire wr_mlen = cfg_wr_i && (cfg_addr_i == OFF_MAKER_LEN);
    wire wr_plen = cfg_wr_i && (cfg_addr_i == OFF_PART_LEN);
    wire wr_ulen = cfg_wr_i && (cfg_addr_i == OFF_UNIT_LEN);

    logic [7:0] reg_sel;
    always_comb begin
        case (cfg_addr_i)
            OFF_CUR_SELF: reg_sel = cur_self_r;
            OFF_CUR_BUS: reg_sel = cur_bus_r;
            OFF_SETTLE: reg_sel = settle_r;
            OFF_LANG_UP: reg_sel = lang_up_r;
            OFF_LANG_LO: reg_sel = lang_lo_r;
            OFF_MAKER_LEN: reg_sel = maker_len_r;
            OFF_PART_LEN: reg_sel = part_len_r;
            OFF_UNIT_LEN: reg_sel = unit_len_r;
            default: reg_sel = RD_UNMAPPED;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    hcs_text_if tif ();
    assign tif.we = wr_text;
    assign tif.wr_idx = text_off[5:1];
    assign tif.wr_hi = text_off[0];
    assign tif.wdata = cfg_wdata_i;
    assign tif.ra_idx = text_off[5:1];
    assign tif.rb_idx = text_char_idx_i;

    hcs_text_mem u_mem (
        .ref_clk_i(ref_clk_i),
        .tif(tif)
    );

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            cur_self_r <= RST_OTHER;
            cur_bus_r <= RST_CUR_BUS;
            settle_r <= RST_OTHER;
            lang_up_r <= RST_OTHER;
            lang_lo_r <= RST_OTHER;
            maker_len_r <= RST_OTHER;
            part_len_r <= RST_OTHER;
            unit_len_r <= RST_OTHER;
        end else begin
            if (wr_self) cur_self_r <= cfg_wdata_i;
            if (wr_bus) cur_bus_r <= cfg_wdata_i;
            if (wr_settle) settle_r <= cfg_wdata_i;
            if (wr_lang_up) lang_up_r <= cfg_wdata_i;
            if (wr_lang_lo) lang_lo_r <= cfg_wdata_i;
            if (wr_mlen) maker_len_r <= cfg_wdata_i;
            if (wr_plen) part_len_r <= cfg_wdata_i;
            if (wr_ulen) unit_len_r <= cfg_wdata_i;
        end
    end

    // Plain 2 mA scaling; no embedded-peripheral share is added
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            self_ma_r <= '0;
            bus_ma_r <= {RST_CUR_BUS, 1'b0};
            lang_r <= '0;
        end else begin
            self_ma_r <= {cur_self_r, 1'b0};
            bus_ma_r <= {cur_bus_r, 1'b0};
            lang_r <= {lang_up_r, lang_lo_r};
        end
    end

    assign self_powered_ma_o = self_ma_r;
    assign bus_powered_ma_o = bus_ma_r;
    assign language_id_o = lang_r;
    // Oversized counts are reported as 31 so a descriptor never overruns
    assign maker_text_char_count_o = clamp_count(maker_len_r);
    assign part_text_char_count_o = clamp_count(part_len_r);
    assign unit_number_text_char_count_o = clamp_count(unit_len_r);

    ////////////////////////////////////////////////////////////////////////
    // Two-cycle read so text bytes, which sit behind a registered
    // memory, answer at the same latency as plain registers
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            rd_pend_r <= 1'b0;
            rd_text_r <= 1'b0;
            rd_hi_r <= 1'b0;
            reg_rd_r <= RST_OTHER;
            rvalid_r <= 1'b0;
            rdata_r <= RST_OTHER;
            char_valid_r <= 1'b0;
        end else begin
            rd_pend_r <= cfg_rd_i;
            rd_text_r <= in_text(cfg_addr_i);
            rd_hi_r <= text_off[0];
            reg_rd_r <= reg_sel;
            rvalid_r <= rd_pend_r;
            if (rd_pend_r) begin
                rdata_r <= !rd_text_r ? reg_rd_r
                         : rd_hi_r ? tif.ra_word[15:8]
                         : tif.ra_word[7:0];
            end
            char_valid_r <= text_char_rd_i;
        end
    end

    assign cfg_rdata_o = rdata_r;
    assign cfg_rvalid_o = rvalid_r;
    assign text_char_o = tif.rb_word;
    assign text_char_valid_o = char_valid_r;

    ////////////////////////////////////////////////////////////////////////
    hcs_settle_type st_r;
    hcs_settle_type st_nxt;
    logic [UNIT_CNT_W-1:0] unit_cnt_r;
    logic [7:0] units_left_r;
    wire unit_tick = (unit_cnt_r == UNIT_CNT_W'(SETTLE_UNIT_CYCLES - 1));

    always_comb begin
        case (st_r)
            SETTLE_IDLE, SETTLE_DONE: st_nxt = !port_power_start_i ? st_r
                : (settle_r == 8'h00) ? SETTLE_DONE : SETTLE_WAIT;
            SETTLE_WAIT: st_nxt = port_power_start_i
                ? ((settle_r == 8'h00) ? SETTLE_DONE : SETTLE_WAIT)
                : (unit_tick && units_left_r == 8'h01) ? SETTLE_DONE
                : SETTLE_WAIT;
            default: st_nxt = SETTLE_IDLE;
        endcase
    end

    // A new start restarts the wait from the programmed value
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            st_r <= SETTLE_IDLE;
            unit_cnt_r <= '0;
            units_left_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            if (port_power_start_i) begin
                unit_cnt_r <= '0;
                units_left_r <= settle_r;
            end else if (st_r == SETTLE_WAIT) begin
                unit_cnt_r <= unit_tick ? '0 : unit_cnt_r + 1'b1;
                if (unit_tick) units_left_r <= units_left_r - 8'h01;
            end
        end
    end

    assign port_power_stable_o = (st_r == SETTLE_DONE);

    ////////////////////////////////////////////////////////////////////////
    sequence s_text_low_wr;
        cfg_wr_i && (cfg_addr_i == OFF_TEXT_FIRST);
    endsequence
    sequence s_char0_rd;
        !cfg_wr_i ##1 (text_char_rd_i && text_char_idx_i == 5'h00);
    endsequence

    bus_reset_val_a: assert property (@(posedge ref_clk_i)
        !rst_b_i |=> cur_bus_r == 8'h32 ##1 bus_powered_ma_o == 9'h064)
        else $error("bus current reset value wrong");
    self_ma_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        wr_self ##1 !wr_self |=> self_powered_ma_o ==
        {$past(cfg_wdata_i, 2), 1'b0})
        else $error("self-powered mA not twice the written count");
    bus_ma_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        wr_bus ##1 !wr_bus |=> bus_powered_ma_o ==
        {$past(cfg_wdata_i, 2), 1'b0})
        else $error("bus-powered mA not twice the written count");
    lang_upper_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        wr_lang_up ##1 !wr_lang_up |=> language_id_o[15:8] ==
        $past(cfg_wdata_i, 2))
        else $error("language upper byte wrong");
    lang_lower_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        wr_lang_lo ##1 !wr_lang_lo |=> language_id_o[7:0] ==
        $past(cfg_wdata_i, 2))
        else $error("language lower byte wrong");
    count_clamp_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        maker_text_char_count_o <= 5'h1F &&
        (maker_len_r > 8'h1F || maker_text_char_count_o == maker_len_r[4:0]))
        else $error("maker char count not clamped to 31");
    char_order_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_text_low_wr ##1 s_char0_rd |=> text_char_valid_o &&
        text_char_o[7:0] == $past(cfg_wdata_i, 3))
        else $error("first text byte not in character low lane");
    read_back_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        cfg_rd_i && !cfg_wr_i && cfg_addr_i == OFF_SETTLE ##1 !wr_settle
        |=> cfg_rvalid_o && cfg_rdata_o == settle_r)
        else $error("settle register read back wrong");
    unmapped_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        cfg_rd_i && cfg_addr_i > OFF_TEXT_LAST |-> ##2
        cfg_rvalid_o && cfg_rdata_o == 8'h00)
        else $error("read past text area not zero");
    settle_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        port_power_start_i && settle_r == 8'h00 |=> port_power_stable_o)
        else $error("zero settle not immediate");
    settle_wait_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        port_power_start_i && settle_r != 8'h00 |=> !port_power_stable_o)
        else $error("stable reported before settle time");
endmodule

//--- hcs_cfg_src.sv
// Configuration source model: byte loader writing and reading registers
`timescale 1ns/1ps
module hcs_cfg_src import hcs_pkg::*; (
    input wire logic ref_clk_i,
    output logic [ADDR_W-1:0] cfg_addr_o,
    output logic cfg_wr_o,
    output logic [DATA_W-1:0] cfg_wdata_o,
    output logic cfg_rd_o
);
    initial begin
        cfg_addr_o = 8'h00;
        cfg_wr_o = 1'b0;
        cfg_wdata_o = 8'h00;
        cfg_rd_o = 1'b0;
    end
    ////////////////////////////////////////
    // Called just after a rising edge; each call spans one edge
    task automatic xfer(input logic w, input logic r, input logic [7:0] a,
                        input logic [7:0] d);
        cfg_wr_o <= w;
        cfg_rd_o <= r;
        // Released lines toggle so stale data never looks valid
        cfg_addr_o <= (w || r) ? a : ~cfg_addr_o;
        cfg_wdata_o <= w ? d : ~cfg_wdata_o;
        @(posedge ref_clk_i);
    endtask
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, 1'b0, a, d);
    endtask
    task automatic read_byte(input logic [7:0] a);
        xfer(1'b0, 1'b1, a, 8'h00);
    endtask
    task automatic idle();
        xfer(1'b0, 1'b0, 8'h00, 8'h00);
    endtask
    // Never above 50 units, the 100 mA ceiling
    task automatic write_self_current(input logic [7:0] u);
        write_byte(OFF_CUR_SELF, (u > 8'h32) ? 8'h32 : u);
    endtask
    // Low byte at the even offset, high byte next
    task automatic write_char(input logic [4:0] k, input logic [15:0] w);
        write_byte(OFF_TEXT_FIRST + {2'b00, k, 1'b0}, w[7:0]);
        write_byte(OFF_TEXT_FIRST + {2'b00, k, 1'b1}, w[15:8]);
    endtask
endmodule

//--- hcs_top_tb.sv
// Self-checking bench for the hub configuration register bank
`timescale 1ns/1ps
module hcs_top_tb import hcs_pkg::*;;
    localparam int unsigned UNIT = 4;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr, wdata, rdata;
    logic wr, rd_s, rvalid, stable, t_valid;
    logic start = 1'b0;
    logic t_rd = 1'b0;
    logic [MA_W-1:0] self_ma, bus_ma;
    logic [15:0] lang, t_char;
    logic [4:0] c_mk, c_pt, c_un;
    logic [4:0] t_idx = 5'h00;
    logic [31:0] rng = 32'h9F22;
    logic [7:0] regs [8'h0E:8'h15];
    logic [15:0] words [0:30];
    logic [7:0] rq [$];
    logic [15:0] tq [$];
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    hcs_cfg_src i_src (.ref_clk_i(clk), .cfg_addr_o(addr), .cfg_wr_o(wr),
        .cfg_wdata_o(wdata), .cfg_rd_o(rd_s));
    hcs_top #(.SETTLE_UNIT_CYCLES(UNIT)) i_dut (.ref_clk_i(clk),
        .rst_b_i(rst_b), .cfg_addr_i(addr), .cfg_wr_i(wr),
        .cfg_wdata_i(wdata), .cfg_rd_i(rd_s), .cfg_rdata_o(rdata),
        .cfg_rvalid_o(rvalid), .self_powered_ma_o(self_ma),
        .bus_powered_ma_o(bus_ma), .language_id_o(lang),
        .maker_text_char_count_o(c_mk), .part_text_char_count_o(c_pt),
        .unit_number_text_char_count_o(c_un), .port_power_start_i(start),
        .port_power_stable_o(stable), .text_char_idx_i(t_idx),
        .text_char_rd_i(t_rd), .text_char_o(t_char),
        .text_char_valid_o(t_valid));
    initial forever #12.5 clk = ~clk;
    ////////////////////////////////////////
    function automatic logic [31:0] xs();
        logic [31:0] s;
        s = rng;
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        rng = s;
        return s;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rq.push_back(exp);
        i_src.read_byte(a);
    endtask
    task automatic settle(input logic [7:0] n, input bit again);
        i_src.write_byte(OFF_SETTLE, n);
        i_src.idle();
        start <= 1'b1;
        @(posedge clk);
        if (again) begin
            start <= 1'b0;
            repeat (2) @(posedge clk);
            start <= 1'b1;
            @(posedge clk);
        end
        start <= 1'b0;
        // Stable rises on the edge n units after the start edge
        if (n != 0) begin
            repeat (n * UNIT - 1) @(posedge clk);
            #1 chk(16'(stable), 16'h0000, "settle early");
            @(posedge clk);
        end
        #1 chk(16'(stable), 16'h0001, "settle end");
        @(posedge clk);
    endtask
    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    // Answers are taken off the queues in order of request
    always @(negedge clk) begin
        if (rvalid === 1'b1) begin
            if (rq.size() == 0) chk(16'h0001, 16'h0000, "stray answer");
            else chk(16'(rdata), 16'(rq.pop_front()), "read data");
        end
        if (t_valid === 1'b1) begin
            if (tq.size() == 0) chk(16'h0001, 16'h0000, "stray char");
            else chk(t_char, tq.pop_front(), "text char");
        end
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            $display("[FAIL] t=%0t run did not finish", $time);
            results();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int a = 8'h0D; a <= 8'h15; a++)
            rd(8'(a), (a == 8'h0F) ? RST_CUR_BUS : RST_OTHER);
        rd(8'h54, RD_UNMAPPED);
        i_src.idle();
        repeat (3) @(posedge clk);
        chk(16'(bus_ma), 16'h0064, "bus mA at reset");
        $display("test reset values done");
        regs[8'h0E] = 8'(xs() % 51);
        for (int a = 8'h0F; a <= 8'h12; a++) regs[a] = 8'(xs());
        regs[8'h13] = 8'h28;
        regs[8'h14] = 8'h1F;
        regs[8'h15] = 8'(xs() % 64);
        i_src.write_self_current(regs[8'h0E]);
        for (int a = 8'h0F; a <= 8'h15; a++)
            i_src.write_byte(8'(a), regs[a]);
        i_src.write_byte(8'h54, 8'hA5);
        i_src.write_byte(8'h0D, 8'h5A);
        for (int a = 8'h0E; a <= 8'h15; a++) rd(8'(a), regs[a]);
        rd(8'h54, RD_UNMAPPED);
        rd(8'h0D, RD_UNMAPPED);
        rq.push_back(regs[8'h11]);
        i_src.xfer(1'b1, 1'b1, OFF_LANG_UP, ~regs[8'h11]);
        regs[8'h11] = ~regs[8'h11];
        rd(OFF_LANG_UP, regs[8'h11]);
        i_src.idle();
        repeat (4) @(posedge clk);
        chk(16'(self_ma), 16'({regs[8'h0E], 1'b0}), "self mA");
        chk(16'(bus_ma), 16'({regs[8'h0F], 1'b0}), "bus mA");
        chk(lang, {regs[8'h11], regs[8'h12]}, "language id");
        chk(16'(c_mk), 16'h001F, "maker count");
        chk(16'(c_pt), 16'h001F, "part count");
        chk(16'(c_un), (regs[8'h15] > 8'h1F) ? 16'h001F
            : 16'(regs[8'h15]), "unit count");
        $display("test registers done");
        for (int k = 0; k < 31; k++) begin
            words[k] = 16'(xs());
            i_src.write_char(5'(k), words[k]);
        end
        // Lone low-byte rewrite, then char 0 read two edges later
        words[0][7:0] = 8'(xs());
        i_src.write_byte(OFF_TEXT_FIRST, words[0][7:0]);
        i_src.idle();
        for (int k = 0; k < 31; k++) begin
            t_idx <= 5'(k);
            t_rd <= 1'b1;
            tq.push_back(words[k]);
            @(posedge clk);
        end
        t_rd <= 1'b0;
        rd(OFF_TEXT_LAST, words[30][15:8]);
        rd(OFF_TEXT_FIRST, words[0][7:0]);
        i_src.idle();
        repeat (4) @(posedge clk);
        $display("test text done");
        settle(8'h00, 1'b0);
        settle(8'(xs() % 3 + 1), 1'b0);
        settle(8'h02, 1'b1);
        $display("test settle done");
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(OFF_CUR_BUS, RST_CUR_BUS);
        rd(OFF_LANG_UP, RST_OTHER);
        i_src.idle();
        repeat (4) @(posedge clk);
        chk(16'(bus_ma), 16'h0064, "bus mA after reset");
        chk(16'(stable), 16'h0000, "stable after reset");
        $display("test second reset done");
        results();
    end
endmodule
